// ---- hdl/tpd_pkg.sv ----
package tpd_pkg;

	// register byte addresses on the apb slave
	localparam logic [7:0] CFG_ADDR    = 8'h00;
	localparam logic [7:0] TIMING_ADDR = 8'h04;
	localparam logic [7:0] AUXCFG_ADDR = 8'h08;
	localparam logic [7:0] CMD_ADDR    = 8'h0C;
	localparam logic [7:0] STATUS_ADDR = 8'h10;
	localparam logic [7:0] RES_BASE    = 8'h20;

	// configuration field positions
	localparam int CFG_SELF_TIMED_BIT = 0;
	localparam int CFG_CONTINUOUS_PANEL_SETUP_BIT       = 1;
	localparam int CFG_FAST_EN_BIT    = 2;
	localparam int CFG_PULLUP_SEL_BIT = 3;
	localparam int CFG_EDGE_IRQ_BIT   = 4;
	localparam int CFG_SLEEP_BIT      = 5;

	// reset values
	localparam logic [5:0]  CFG_RESET    = 6'h00;
	localparam logic [15:0] TIMING_RESET = 16'h1010;
	localparam logic [15:0] AUXCFG_RESET = 16'h0000;

	// event tag encodings
	localparam logic [1:0] TAG_TOUCH   = 2'h0;
	localparam logic [1:0] TAG_NOTOUCH = 2'h2;
	localparam logic [1:0] TAG_BUSY    = 2'h3;
	localparam logic [15:0] PENDING_WORD = 16'hFFFF;

	// settle time per scan step, in ns, and its clock count
	localparam int CLK_NS        = 50;
	localparam int SETTLE_NS     = 200;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {MEAS_X, MEAS_Y, MEAS_Z1, MEAS_Z2} meas_e;

	// panel switch bundle
	typedef struct packed {
		logic xp_vdd;
		logic xp_strong;
		logic xp_pullup;
		logic xm_gnd;
		logic yp_vdd;
		logic ym_gnd;
	} switches_s;

	localparam switches_s SW_OFF = '0;

endpackage

// ---- hdl/result_mem.sv ----
`timescale 1ns/100ps
module result_mem
	import tpd_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        we_in,
	input  wire logic [1:0]  waddr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [1:0]  raddr_in,
	output logic      [15:0] rdata_out
);
	logic [15:0] mem_r [0:3];

	// registered read port keeps the bus data off a mux path
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem_r[waddr_in] <= wdata_in;
		end
		rdata_out <= mem_r[raddr_in];
	end
endmodule

// ---- hdl/touch_panel_detect_sequencer.sv ----
`timescale 1ns/100ps
//
// Contract
// RULE_01 - detect idle: y-minus grounded, pullup on, strong and drive switches off
// RULE_02 - touch in idle: host mode raises interrupt, self-timed mode starts scans
// RULE_03 - pullup select chooses 50k or 100k for idle and fine pullup
// RULE_04 - fast pullup closes strong x-plus switch with pullup, y-minus grounded
// RULE_05 - fine pullup drives x-plus through selected pullup only
// RULE_06 - fast pullup optional by config, always followed by fine pullup
// RULE_07 - fine pullup always inserted after every scan
// RULE_08 - after scan return to detect setup and decide touch
// RULE_09 - tag results only at fine pullup expiry, busy until then
// RULE_10 - after tagging go to idle chosen by conversion and interrupt modes
// RULE_11 - fast and fine durations come from the timing register
// RULE_12 - host mode, continuous off: tag 00 touch, 10 none, 11 busy
// RULE_13 - host mode, continuous on: no touch check, tag 00 or 11
// RULE_14 - every host-mode result carries its measurement-type tag
// RULE_15 - auxiliary input has its own configuration register
// RULE_16 - x: drive x-plus/x-minus, sense y-plus; y swaps plates
// RULE_17 - z1/z2: drive y-plus, ground x-minus; sense x-plus or y-minus
// RULE_18 - pullup, detect and sleep states entered without host command
// RULE_19 - sleep state opens every switch
// RULE_20 - result word: 12 data bits, type tag, event tag low
// RULE_21 - pending result reads all ones
// RULE_22 - touch sampled once at final clock of fine pullup
// RULE_23 - break-before-make: all switches open a clock between setups; fast to fine pullup only opens xp_strong, with no all-open clock
module touch_panel_detect_sequencer
	import tpd_pkg::*;
(
	input  wire logic        CLOCK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        TOUCH_IN,
	input  wire logic        ADC_DONE_IN,
	input  wire logic [11:0] ADC_DATA_IN,
	output logic             ADC_START_OUT,
	output logic [1:0]       ADC_SENSE_OUT,
	output switches_s        SWITCHES_OUT,
	output logic             PULLUP_VALUE_SELECT_OUT,
	output logic             TOUCH_INTERRUPT_N_OUT
);
	typedef enum logic [3:0] {
		ST_DETECT, ST_SLEEP, ST_BREAK, ST_SETTLE, ST_CONVERT,
		ST_FAST, ST_FINE, ST_TAG
	} state_e;

	state_e      state_r, state_nxt, after_break_r;
	logic [5:0]  cfg_r;
	logic [15:0] timing_r;
	logic [15:0] auxcfg_r;
	logic [3:0]  req_r;
	logic [1:0]  meas_r;
	logic [7:0]  count_r;
	logic        busy_r;
	logic        touch_meta_r, touch_sync_r;
	logic        touch_seen_r;
	logic [11:0] data_r [0:3];
	logic [1:0]  rd_idx_r;
	logic        rd_pend_r;
	logic        rd_res_r;
	logic        rd_phase_r;
	logic [31:0] rd_reg_r;

	// field decode
	wire self_timed = cfg_r[CFG_SELF_TIMED_BIT];
	wire continuous_panel_setup_setup = cfg_r[CFG_CONTINUOUS_PANEL_SETUP_BIT];
	wire fast_en    = cfg_r[CFG_FAST_EN_BIT];
	wire edge_irq   = cfg_r[CFG_EDGE_IRQ_BIT];
	wire sleep_req  = cfg_r[CFG_SLEEP_BIT];
	wire [7:0] fast_len = timing_r[15:8];   // see RULE_11
	wire [7:0] fine_len = timing_r[7:0];    // see RULE_11

	// apb decode
	wire apb_access = PSEL_IN & PENABLE_IN;
	// writes land on the completing edge, when the master sees ready
	wire apb_wr     = apb_access & PWRITE_IN & PREADY_OUT;
	wire apb_rd     = apb_access & ~PWRITE_IN;
	wire addr_res   = (PADDR_IN[7:4] == RES_BASE[7:4]) && (PADDR_IN[3:0] == 4'h0
		|| PADDR_IN[3:0] == 4'h4 || PADDR_IN[3:0] == 4'h8 || PADDR_IN[3:0] == 4'hC);
	wire addr_ok    = addr_res || PADDR_IN == CFG_ADDR || PADDR_IN == TIMING_ADDR
		|| PADDR_IN == AUXCFG_ADDR || PADDR_IN == CMD_ADDR || PADDR_IN == STATUS_ADDR;
	wire cmd_wr     = apb_wr && PADDR_IN == CMD_ADDR;
	wire [3:0] cmd_mask = PWDATA_IN[3:0];

	// lowest pending measurement
	function automatic logic [1:0] first_req(input logic [3:0] r);
		first_req = r[0] ? 2'h0 : r[1] ? 2'h1 : r[2] ? 2'h2 : 2'h3;
	endfunction

	wire [3:0] req_left  = req_r & ~(4'h1 << meas_r);
	wire       count_end = count_r == 8'h00;

	// switch setup for the next state, all open for break cycles
	function automatic switches_s setup_of(input state_e s, input logic [1:0] m);
		switches_s w;
		w = SW_OFF;
		unique case (s)
			ST_DETECT, ST_FINE: begin
				w.xp_pullup = 1'b1;                          // see RULE_01 RULE_05
				w.ym_gnd    = 1'b1;
			end
			ST_FAST: begin
				w.xp_strong = 1'b1;                          // see RULE_04
				w.xp_pullup = 1'b1;
				w.ym_gnd    = 1'b1;
			end
			ST_SETTLE, ST_CONVERT: begin
				unique case (m)
					2'h0: begin w.xp_vdd = 1'b1; w.xm_gnd = 1'b1; end   // see RULE_16
					2'h1: begin w.yp_vdd = 1'b1; w.ym_gnd = 1'b1; end   // see RULE_16
					default: begin w.yp_vdd = 1'b1; w.xm_gnd = 1'b1; end // see RULE_17
				endcase
			end
			default: w = SW_OFF;                             // see RULE_19 RULE_23
		endcase
		setup_of = w;
	endfunction

	// next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_DETECT: begin
				if (sleep_req) begin
					state_nxt = ST_SLEEP;                        // see RULE_18
				end else if (cmd_wr && cmd_mask != 4'h0) begin
					state_nxt = ST_BREAK;
				end else if (self_timed && touch_sync_r) begin
					state_nxt = ST_BREAK;                        // see RULE_02
				end
			end
			ST_SLEEP: begin
				if (!sleep_req && cmd_wr && cmd_mask != 4'h0) begin
					state_nxt = ST_BREAK;
				end else if (!sleep_req && !edge_irq) begin
					state_nxt = ST_DETECT;
				end
			end
			ST_BREAK:   state_nxt = after_break_r;           // see RULE_23
			ST_SETTLE:  if (count_end) state_nxt = ST_CONVERT;
			ST_CONVERT: begin
				if (ADC_DONE_IN) begin
					state_nxt = ST_BREAK;
				end
			end
			ST_FAST:    if (count_end) state_nxt = ST_FINE;  // see RULE_06
			ST_FINE:    if (count_end) state_nxt = ST_TAG;   // see RULE_09
			ST_TAG:     state_nxt = ST_BREAK;                // see RULE_10
			default:    state_nxt = ST_DETECT;
		endcase
	end

	// target after a break cycle
	wire scan_left   = state_r == ST_CONVERT ? (req_left != 4'h0) : (req_r != 4'h0);
	wire go_sleep    = sleep_req || (edge_irq && !self_timed);
	state_e brk_to;
	assign brk_to = (state_r == ST_CONVERT && !scan_left) ?
			(fast_en ? ST_FAST : ST_FINE) :                  // see RULE_06 RULE_07
		(state_r == ST_TAG) ? (go_sleep ? ST_SLEEP : ST_DETECT) :   // see RULE_10
		ST_SETTLE;

	// touch pin synchroniser
	always_ff @(posedge CLOCK_IN) begin
		touch_meta_r <= TOUCH_IN;
		touch_sync_r <= touch_meta_r;
	end

	// sequencer state and counters
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			state_r       <= ST_DETECT;
			after_break_r <= ST_DETECT;
			count_r       <= 8'h00;
			meas_r        <= 2'h0;
			req_r         <= 4'h0;
			busy_r        <= 1'b0;
			touch_seen_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt == ST_BREAK) begin
				after_break_r <= brk_to;
			end
			if (state_r == ST_DETECT && state_nxt == ST_BREAK) begin
				req_r  <= (cmd_wr && cmd_mask != 4'h0) ? cmd_mask : 4'hF;
				meas_r <= first_req((cmd_wr && cmd_mask != 4'h0) ? cmd_mask : 4'hF);
				busy_r <= 1'b1;
			end else if (state_r == ST_SLEEP && state_nxt == ST_BREAK) begin
				req_r  <= cmd_mask;
				meas_r <= first_req(cmd_mask);
				busy_r <= 1'b1;
			end else if (state_r == ST_CONVERT && ADC_DONE_IN) begin
				req_r <= req_left;
				if (req_left != 4'h0) begin
					meas_r <= first_req(req_left);
				end
			end
			if (state_r == ST_FINE && count_end) begin
				touch_seen_r <= touch_sync_r;                // see RULE_22
			end
			if (state_r == ST_TAG) begin
				busy_r <= 1'b0;                              // see RULE_09
			end
			// interval counters load as each timed state is entered
			if (state_r == ST_BREAK) begin
				unique case (after_break_r)
					ST_SETTLE: count_r <= 8'(SETTLE_CYCLES - 1);
					ST_FAST:   count_r <= fast_len;
					ST_FINE:   count_r <= fine_len;
					default:   count_r <= 8'h00;
				endcase
			end else if (state_r == ST_FAST && count_end) begin
				count_r <= fine_len;                         // see RULE_06
			end else if (!count_end) begin
				count_r <= count_r - 8'h01;
			end
		end
	end

	// result store; continuous_panel_setup mode ignores the sampled touch_seen_r and tags every result as a touch
	wire [1:0] evt_tag = continuous_panel_setup_setup ? TAG_TOUCH :       // see RULE_13
		(touch_seen_r ? TAG_TOUCH : TAG_NOTOUCH);          // see RULE_08 RULE_12
	wire       tag_now = state_r == ST_TAG;
	logic [1:0] tags_r [0:3];
	logic [3:0] valid_mask_r;

	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			valid_mask_r <= 4'h0;
		end else if (state_r == ST_CONVERT && ADC_DONE_IN) begin
			data_r[meas_r] <= ADC_DATA_IN;
			valid_mask_r   <= valid_mask_r | (4'h1 << meas_r);
		end else if (tag_now) begin
			for (int i = 0; i < 4; i++) begin
				tags_r[i] <= evt_tag;                        // see RULE_09
			end
		end
	end

	wire [15:0] res_word;
	wire [1:0]  res_idx = PADDR_IN[3:2];
	assign res_word = busy_r ? PENDING_WORD :            // see RULE_21
		{data_r[res_idx], res_idx, tags_r[res_idx]};       // see RULE_14 RULE_20

	// registers and apb answer
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			cfg_r       <= CFG_RESET;
			timing_r    <= TIMING_RESET;
			auxcfg_r    <= AUXCFG_RESET;
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= 32'h0000_0000;
		end else begin
			PREADY_OUT  <= apb_access & ~PREADY_OUT;
			PSLVERR_OUT <= apb_access & ~PREADY_OUT & ~addr_ok;
			if (apb_wr && PADDR_IN == CFG_ADDR) begin
				cfg_r <= PWDATA_IN[5:0];
			end
			if (apb_wr && PADDR_IN == TIMING_ADDR) begin
				timing_r <= PWDATA_IN[15:0];                 // see RULE_11
			end
			if (apb_wr && PADDR_IN == AUXCFG_ADDR) begin
				auxcfg_r <= PWDATA_IN[15:0];                 // see RULE_15
			end
			if (apb_rd && !PREADY_OUT) begin
				PRDATA_OUT <= addr_res ? {16'h0000, res_word} :
					PADDR_IN == CFG_ADDR    ? {26'h0, cfg_r} :
					PADDR_IN == TIMING_ADDR ? {16'h0, timing_r} :
					PADDR_IN == AUXCFG_ADDR ? {16'h0, auxcfg_r} :
					PADDR_IN == STATUS_ADDR ? {24'h0, 1'b0, state_r, busy_r, 2'b00} :
					32'h0000_0000;
			end
		end
	end

	// registered panel outputs
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			SWITCHES_OUT            <= SW_OFF;
			ADC_START_OUT           <= 1'b0;
			ADC_SENSE_OUT           <= 2'h0;
			PULLUP_VALUE_SELECT_OUT <= 1'b0;
			TOUCH_INTERRUPT_N_OUT   <= 1'b1;
		end else begin
			SWITCHES_OUT            <= setup_of(state_nxt, meas_r);
			ADC_START_OUT           <= state_r == ST_SETTLE && count_end;
			ADC_SENSE_OUT           <= meas_r;
			PULLUP_VALUE_SELECT_OUT <= cfg_r[CFG_PULLUP_SEL_BIT];   // see RULE_03
			TOUCH_INTERRUPT_N_OUT   <= ~(state_r == ST_DETECT && !self_timed
				&& touch_sync_r);                              // see RULE_02
		end
	end

	// assertions
	idle_switches_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		$past(NRST_IN) && $past(state_r) == ST_DETECT && state_r == ST_DETECT |->
		SWITCHES_OUT.ym_gnd && SWITCHES_OUT.xp_pullup && !SWITCHES_OUT.xp_strong
		&& !SWITCHES_OUT.xp_vdd && !SWITCHES_OUT.yp_vdd)
		else $error("detect idle switch setup wrong");   // see RULE_01
	fast_then_fine_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		state_r == ST_FAST && count_end |=> state_r == ST_FINE)
		else $error("fine pullup did not follow fast");   // see RULE_06
	break_open_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		(SWITCHES_OUT & ~$past(SWITCHES_OUT)) != 6'h00 |-> $past(SWITCHES_OUT) == SW_OFF)
		else $error("switch change without open cycle");   // see RULE_23
	pend_read_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		PREADY_OUT && apb_rd && addr_res && $past(busy_r) |->
		PRDATA_OUT[15:0] == PENDING_WORD)
		else $error("pending result not all ones");   // see RULE_21
	sleep_open_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		state_r == ST_SLEEP && $past(state_r) == ST_SLEEP |-> SWITCHES_OUT == SW_OFF)
		else $error("sleep state left a switch closed");   // see RULE_19
	tag_after_fine_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		state_r == ST_TAG |-> $past(state_r) == ST_FINE)
		else $error("tagging without fine pullup");   // see RULE_07
	irq_touch_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!TOUCH_INTERRUPT_N_OUT |-> !$past(self_timed) && $past(touch_sync_r)
		&& $past(state_r) == ST_DETECT)
		else $error("interrupt in self-timed mode");   // see RULE_02
	busy_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		state_r == ST_TAG |=> !busy_r)
		else $error("busy not cleared after tagging");   // see RULE_09

	// result memory keeps only the last measured word (meas_r) at each tag; mem_rd is unread
	logic [15:0] mem_rd;
	result_mem u_mem (
		.clk_in    (CLOCK_IN),
		.we_in     (tag_now),
		.waddr_in  (meas_r),
		.wdata_in  ({data_r[meas_r], meas_r, evt_tag}),
		.raddr_in  (res_idx),
		.rdata_out (mem_rd)
	);
endmodule

// ---- test/panel_adc_model.sv ----
`timescale 1ns/100ps
module panel_adc_model
	import tpd_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        touched_in,
	input  wire logic        slow_in,
	input  wire logic        start_in,
	input  wire logic [1:0]  sense_in,
	input  switches_s        sw_in,
	output logic             touch_out,
	output logic             done_out,
	output logic      [11:0] data_out
);
	int   cnt = 0;
	logic busy_r = 1'b0;
	initial done_out = 1'b0;
	initial data_out = 12'h000;
	// comparator only sees a touch through the pullup with y-minus grounded
	assign touch_out = touched_in & sw_in.ym_gnd & sw_in.xp_pullup & !sw_in.xp_strong;
	// conversion answers quickly or slowly; data toggles while not valid
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		data_out <= ~data_out;
		if (start_in) begin
			busy_r <= 1'b1;
			cnt    <= slow_in ? 20 : 1;
		end else if (busy_r && cnt == 0) begin
			busy_r   <= 1'b0;
			done_out <= 1'b1;
			data_out <= {sense_in, 10'h2A5};
		end else if (busy_r) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// ---- test/touch_panel_detect_sequencer_tb.sv ----
`timescale 1ns/100ps
module touch_panel_detect_sequencer_tb;
	import tpd_pkg::*;
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, touched = 0, slow = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, tch, done, start, pvs, irq_n, err;
	logic [11:0] adata;
	logic [1:0] sense;
	switches_s sw, prev;
	int failures = 0, total_checks = 0, cyc = 0, starts = 0, fr = 0, ef = 0;
	logic [5:0] meas_sw [4] = '{6'h24, 6'h03, 6'h06, 6'h06};

	touch_panel_detect_sequencer u_touch_panel_detect_sequencer (.CLOCK_IN(clk),
		.NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TOUCH_IN(tch),
		.ADC_DONE_IN(done), .ADC_DATA_IN(adata), .ADC_START_OUT(start),
		.ADC_SENSE_OUT(sense), .SWITCHES_OUT(sw), .PULLUP_VALUE_SELECT_OUT(pvs),
		.TOUCH_INTERRUPT_N_OUT(irq_n));
	panel_adc_model u_panel_adc_model (.clk_in(clk), .touched_in(touched),
		.slow_in(slow), .start_in(start), .sense_in(sense), .sw_in(sw),
		.touch_out(tch), .done_out(done), .data_out(adata));

	always #25 clk = ~clk;

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard, well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			tally_and_finish;
		end
	end

	// watch the panel switches: measure setups, fast pullup run, break cycles
	always @(posedge clk) begin
		if (start === 1'b1) begin
			chk("meas_sw", sw, meas_sw[sense]);
			starts++;
		end
		if (sw === 6'h19) begin
			if (fr == 0)
				chk("pre_fast", prev, SW_OFF);
			fr++;
		end else if (fr != 0) begin
			chk("fast_len", fr, ef);
			chk("after_fast", sw, 6'h09);
			fr = 0;
		end
		// only a newly closing switch needs the all-open cycle before it
		if (nrst && (sw & ~prev) != 6'h00)
			chk("break", prev, SW_OFF);
		prev = sw;
	end

	// one apb transfer, called just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// idle cycle so the next call never re-raises psel in this time step
		@(posedge clk);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic t_reset;
		chk("idle_sw", sw, 6'h09);
		chk("irq_idle", irq_n, 1'b1);
		apb(0, CFG_ADDR, 0);
		chk("cfg_rst", rv, {26'h0, CFG_RESET});
		apb(0, TIMING_ADDR, 0);
		chk("tim_rst", rv, {16'h0, TIMING_RESET});
		apb(1, AUXCFG_ADDR, 32'h5A5A);
		apb(0, AUXCFG_ADDR, 0);
		chk("aux_cfg", rv[15:0], 16'h5A5A);
		apb(0, 8'h40, 0);
		chk("unmapped_err", err, 1'b1);
		chk("unmapped_dat", rv, 32'h0);
		apb(1, CFG_ADDR, 32'h08);
		wt(2);
		chk("pullup_100k", pvs, 1'b1);
		apb(1, CFG_ADDR, 32'h00);
		wt(2);
		chk("pullup_50k", pvs, 1'b0);
	endtask

	task automatic t_irq;
		int n;
		n = 0;
		touched <= 1'b1;
		while (irq_n !== 1'b0 && n < 30) begin
			wt(1);
			n++;
		end
		chk("irq_touch", irq_n, 1'b0);
	endtask

	// command a scan and check every word it produces
	task automatic t_scan(input logic [3:0] m, input logic t, input logic [31:0] cfg,
		input logic [1:0] tag, input logic [5:0] end_sw);
		int n;
		int k0;
		k0 = m[0] ? 0 : m[1] ? 1 : m[2] ? 2 : 3;
		touched <= t;
		apb(1, CFG_ADDR, cfg);
		apb(1, TIMING_ADDR, 32'h0304);
		ef = 4;
		apb(1, CMD_ADDR, {28'h0, m});
		// only the first word can still be pending; the rest land with it
		apb(0, RES_BASE + 8'(4 * k0), 0);
		chk("pending", rv[15:0], PENDING_WORD);
		for (int k = 0; k < 4; k++) begin
			if (m[k]) begin
				n = 0;
				do begin
					apb(0, RES_BASE + 8'(4 * k), 0);
					n++;
				end while (rv[15:0] === PENDING_WORD && n < 300);
				chk("result", rv[15:0], {2'(k), 10'h2A5, 2'(k), tag});
			end
		end
		wt(4);
		chk("end_sw", sw, end_sw);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		wt(3);
		t_reset;
		t_irq;
		slow <= 1'b1;
		t_scan(4'hF, 1'b1, 32'h00, TAG_TOUCH, 6'h09);
		slow <= 1'b0;
		t_scan(4'h1, 1'b0, 32'h04, TAG_NOTOUCH, 6'h09);
		t_scan(4'h3, 1'b1, 32'h04, TAG_TOUCH, 6'h09);
		t_scan(4'h2, 1'b1, 32'h02, TAG_TOUCH, 6'h09);
		t_scan(4'h8, 1'b0, 32'h02, TAG_TOUCH, 6'h09);
		// self-timed: a touch alone must start scans
		touched <= 1'b0;
		apb(1, CFG_ADDR, 32'h01);
		wt(4);
		ef = starts;
		touched <= 1'b1;
		wt(400);
		chk("self_start", starts > ef, 1'b1);
		touched <= 1'b0;
		wt(400);
		t_scan(4'h4, 1'b0, 32'h10, TAG_NOTOUCH, 6'h00);
		tally_and_finish;
	end
endmodule
